// file: rtl/gas_pkg.sv
// package: constants shared by the gas alarm supervisor design
package gas_pkg;

	// ----------------------------------------------------------------
	// clock and times in their own units
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned ALARM_DELAY_S  = 20;
	localparam int unsigned WARMUP_S       = 60;
	localparam int unsigned FLASH_MS       = 500;
	localparam int unsigned DEBOUNCE_MS    = 20;
	localparam int unsigned FAULT_HIDE_S   = 3;

	// ----------------------------------------------------------------
	// derived cycle counts
	// ----------------------------------------------------------------
	localparam int unsigned ALARM_DELAY_CYC = CLK_HZ * ALARM_DELAY_S;
	localparam int unsigned WARMUP_CYC      = CLK_HZ * WARMUP_S;
	localparam int unsigned FLASH_CYC       = (CLK_HZ / 1000) * FLASH_MS;
	localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int unsigned FAULT_HIDE_CYC  = CLK_HZ * FAULT_HIDE_S;

	// ----------------------------------------------------------------
	// register map and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [3:0] CTRL_RESET = 4'hF;

	// ----------------------------------------------------------------
	// switch bank bit positions
	// ----------------------------------------------------------------
	localparam int unsigned SW_MUTE  = 0;
	localparam int unsigned SW_NOMEM = 1;
	localparam int unsigned SW_BLOCK = 2;
	localparam int unsigned SW_CLEAR = 3;
	localparam int unsigned SW_TEST  = 4;
	localparam int unsigned SW_COUNT = 5;

endpackage : gas_pkg

// file: rtl/gas_debounce.sv
// module: synchroniser and debouncer for one button or switch
`timescale 1ns/1ps
`default_nettype none
module gas_debounce #(
	parameter int unsigned CYC = gas_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// raw pin
	input  wire logic raw_i,
	// cleaned level and press pulse
	output logic      level_o,
	output logic      rise_o
);

	logic        sync1_q;
	logic        sync2_q;
	logic [31:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= raw_i;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q   <= 32'h0000_0000;
			level_o <= 1'b0;
			rise_o  <= 1'b0;
		end else begin
			rise_o <= 1'b0;
			if (sync2_q == level_o) begin
				cnt_q <= 32'h0000_0000;
			end else if (cnt_q >= CYC - 1) begin
				cnt_q   <= 32'h0000_0000;
				level_o <= sync2_q;
				rise_o  <= sync2_q;
			end else begin
				cnt_q <= cnt_q + 32'h0000_0001;
			end
		end
	end

endmodule : gas_debounce
`default_nettype wire

// file: rtl/gas_qualify.sv
// module: continuous-presence qualification timer
`timescale 1ns/1ps
`default_nettype none
module gas_qualify #(
	parameter int unsigned CYC = gas_pkg::ALARM_DELAY_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// condition and qualified result
	input  wire logic in_i,
	output logic      q_o
);

	logic [31:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || !in_i) begin
			cnt_q <= 32'h0000_0000;
			q_o   <= 1'b0;
		end else if (cnt_q >= CYC - 1) begin
			q_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
		end
	end

endmodule : gas_qualify
`default_nettype wire

// file: rtl/gas_alarm_supervisor.sv
// module: alarm supervisor for up to four two-threshold gas detectors
//
// Function
// - detector alarm lights its input light and sounds intermittent siren.
// - mute switch silences siren only; everything else unchanged.
// - control output and red light only after detector alarm lasts over 20 s; cascade alarm inputs act at once.
// - with memory, cleared alarm turns steady lights into flashing ones.
// - brief clear press extinguishes all flashing memory lights.
// - latch-disable switch: no memory, lights follow alarm signals directly.
// - test held lights output lights, drives outputs; release leaves flashing memory.
// - output-block switch keeps control outputs off while on.
// - detector threshold inputs ignored for 1 min warm-up; fault and cascade inputs stay active.
// - calibration expiry flashes second input light; clear hides it briefly.
// - sensor failure flashes both input lights; clear hides them briefly.
// - supply overload lights both input lights of that detector.
// - clear acts only on flashing lights; active steady alarms stay lit.
// - module power light flashes during warm-up, steady afterwards.
// - fuse trip flashes detector power light and raises second threshold alarm.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module gas_alarm_supervisor #(
	parameter int unsigned NDET       = 4,
	parameter int unsigned DELAY_CYC  = gas_pkg::ALARM_DELAY_CYC,
	parameter int unsigned WARMUP_CYC = gas_pkg::WARMUP_CYC,
	parameter int unsigned FLASH_CYC  = gas_pkg::FLASH_CYC,
	parameter int unsigned DEB_CYC    = gas_pkg::DEBOUNCE_CYC,
	parameter int unsigned HIDE_CYC   = gas_pkg::FAULT_HIDE_CYC
) (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// wishbone slave
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic [31:0]          wb_dat_o,
	output logic                 wb_ack_o,
	// detector signals
	input  wire logic [NDET-1:0] first_threshold_alarm_i,
	input  wire logic [NDET-1:0] second_threshold_alarm_i,
	input  wire logic [NDET-1:0] calibration_expired_i,
	input  wire logic [NDET-1:0] sensor_failed_i,
	input  wire logic [NDET-1:0] supply_overload_i,
	input  wire logic [NDET-1:0] fuse_tripped_i,
	// cascade alarm inputs
	input  wire logic            cascade_first_i,
	input  wire logic            cascade_second_i,
	// function switch bank and buttons
	input  wire logic            siren_mute_switch_i,
	input  wire logic            latch_disable_switch_i,
	input  wire logic            output_block_switch_i,
	input  wire logic            latch_clear_button_i,
	input  wire logic            test_button_i,
	// input status lights
	output logic [NDET-1:0]      first_threshold_light_o,
	output logic [NDET-1:0]      second_threshold_light_o,
	// output status lights and control outputs
	output logic                 first_output_light_o,
	output logic                 second_output_light_o,
	output logic                 first_threshold_output_o,
	output logic                 second_threshold_output_o,
	// power lights and siren
	output logic [NDET-1:0]      detector_power_light_o,
	output logic                 module_power_light_o,
	output logic                 siren_o
);

	// ----------------------------------------------------------------
	// switch conditioning
	// ----------------------------------------------------------------
	logic [gas_pkg::SW_COUNT-1:0] sw_raw;
	logic [gas_pkg::SW_COUNT-1:0] sw_lvl;
	logic [gas_pkg::SW_COUNT-1:0] sw_rise;

	assign sw_raw = {test_button_i, latch_clear_button_i, output_block_switch_i,
		latch_disable_switch_i, siren_mute_switch_i};

	for (genvar s = 0; s < gas_pkg::SW_COUNT; s++) begin : g_sw
		gas_debounce #(
			.CYC     (DEB_CYC)
		) u_deb (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.raw_i   (sw_raw[s]),
			.level_o (sw_lvl[s]),
			.rise_o  (sw_rise[s])
		);
	end

	logic mute;
	logic nomem;
	logic block;
	logic clear_pulse;
	logic test;

	assign mute        = sw_lvl[gas_pkg::SW_MUTE];
	assign nomem       = sw_lvl[gas_pkg::SW_NOMEM];
	assign block       = sw_lvl[gas_pkg::SW_BLOCK];
	assign clear_pulse = sw_rise[gas_pkg::SW_CLEAR];
	assign test        = sw_lvl[gas_pkg::SW_TEST];

	// ----------------------------------------------------------------
	// warm-up timer
	// ----------------------------------------------------------------
	logic [31:0] warm_cnt_q;
	logic        warm_done_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			warm_cnt_q  <= 32'h0000_0000;
			warm_done_q <= 1'b0;
		end else if (!warm_done_q) begin
			if (warm_cnt_q >= WARMUP_CYC - 1) begin
				warm_done_q <= 1'b1;
			end else begin
				warm_cnt_q <= warm_cnt_q + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// flash divider
	// ----------------------------------------------------------------
	logic [31:0] flash_cnt_q;
	logic        flash_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q     <= 1'b0;
		end else if (flash_cnt_q >= FLASH_CYC - 1) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q     <= ~flash_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// fault hide timer
	// ----------------------------------------------------------------
	logic [31:0] hide_cnt_q;
	logic        hide;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hide_cnt_q <= 32'h0000_0000;
		end else if (clear_pulse) begin
			hide_cnt_q <= HIDE_CYC;
		end else if (hide_cnt_q != 32'h0000_0000) begin
			hide_cnt_q <= hide_cnt_q - 32'h0000_0001;
		end
	end

	assign hide = (hide_cnt_q != 32'h0000_0000);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [NDET-1:0] det_en_q;

	// ----------------------------------------------------------------
	// detector alarm conditions and qualification
	// ----------------------------------------------------------------
	logic [NDET-1:0] a1;
	logic [NDET-1:0] a2;
	logic [NDET-1:0] q1;
	logic [NDET-1:0] q2;
	logic [NDET-1:0] a1_prev_q;
	logic [NDET-1:0] a2_prev_q;
	logic [NDET-1:0] mem1_q;
	logic [NDET-1:0] mem2_q;

	for (genvar d = 0; d < NDET; d++) begin : g_det
		assign a1[d] = warm_done_q & det_en_q[d] & first_threshold_alarm_i[d];
		assign a2[d] = det_en_q[d] & ((warm_done_q & second_threshold_alarm_i[d]) | fuse_tripped_i[d]);

		gas_qualify #(
			.CYC   (DELAY_CYC)
		) u_q1 (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.in_i  (a1[d]),
			.q_o   (q1[d])
		);

		gas_qualify #(
			.CYC   (DELAY_CYC)
		) u_q2 (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.in_i  (a2[d]),
			.q_o   (q2[d])
		);

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mem1_q[d] <= 1'b0;
				mem2_q[d] <= 1'b0;
			end else begin
				if (a1_prev_q[d] && !a1[d] && !nomem) begin
					mem1_q[d] <= 1'b1;
				end else if (clear_pulse || nomem || a1[d]) begin
					mem1_q[d] <= 1'b0;
				end
				if (a2_prev_q[d] && !a2[d] && !nomem) begin
					mem2_q[d] <= 1'b1;
				end else if (clear_pulse || nomem || a2[d]) begin
					mem2_q[d] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a1_prev_q <= '0;
			a2_prev_q <= '0;
		end else begin
			a1_prev_q <= a1;
			a2_prev_q <= a2;
		end
	end

	// ----------------------------------------------------------------
	// output activity and output memory
	// ----------------------------------------------------------------
	logic oa1;
	logic oa2;
	logic oa1_prev_q;
	logic oa2_prev_q;
	logic omem1_q;
	logic omem2_q;

	assign oa1 = (|q1) | cascade_first_i | test;
	assign oa2 = (|q2) | cascade_second_i | test;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oa1_prev_q <= 1'b0;
			oa2_prev_q <= 1'b0;
			omem1_q    <= 1'b0;
			omem2_q    <= 1'b0;
		end else begin
			oa1_prev_q <= oa1;
			oa2_prev_q <= oa2;
			if (oa1_prev_q && !oa1 && !nomem) begin
				omem1_q <= 1'b1;
			end else if (clear_pulse || nomem || oa1) begin
				omem1_q <= 1'b0;
			end
			if (oa2_prev_q && !oa2 && !nomem) begin
				omem2_q <= 1'b1;
			end else if (clear_pulse || nomem || oa2) begin
				omem2_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// light and output registers
	// ----------------------------------------------------------------
	logic [NDET-1:0] in1_d;
	logic [NDET-1:0] in2_d;
	logic [NDET-1:0] pwr_d;

	always_comb begin
		for (int d = 0; d < NDET; d++) begin
			in1_d[d] = 1'b0;
			in2_d[d] = 1'b0;
			pwr_d[d] = 1'b0;
			if (det_en_q[d]) begin
				if (supply_overload_i[d]) begin
					in1_d[d] = 1'b1;
					in2_d[d] = 1'b1;
				end else begin
					in1_d[d] = a1[d] | (mem1_q[d] & flash_q);
					in2_d[d] = a2[d] | (mem2_q[d] & flash_q);
					if (sensor_failed_i[d] && !hide && flash_q) begin
						in1_d[d] = 1'b1;
						in2_d[d] = 1'b1;
					end
					if (calibration_expired_i[d] && !hide && flash_q) begin
						in2_d[d] = 1'b1;
					end
				end
				pwr_d[d] = (supply_overload_i[d] || fuse_tripped_i[d]) ? flash_q : 1'b1;
			end
			if (test) begin
				in1_d[d] = 1'b0;
				in2_d[d] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_threshold_light_o  <= '0;
			second_threshold_light_o <= '0;
			detector_power_light_o   <= '0;
		end else begin
			first_threshold_light_o  <= in1_d;
			second_threshold_light_o <= in2_d;
			detector_power_light_o   <= pwr_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_output_light_o      <= 1'b0;
			second_output_light_o     <= 1'b0;
			first_threshold_output_o  <= 1'b0;
			second_threshold_output_o <= 1'b0;
		end else begin
			first_output_light_o      <= oa1 | (omem1_q & flash_q);
			second_output_light_o     <= oa2 | (omem2_q & flash_q);
			first_threshold_output_o  <= oa1 & ~block;
			second_threshold_output_o <= oa2 & ~block;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			siren_o <= 1'b0;
		end else begin
			siren_o <= ((|a1) | (|a2) | cascade_first_i | cascade_second_i) & flash_q & ~mute;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			module_power_light_o <= 1'b0;
		end else begin
			module_power_light_o <= warm_done_q | flash_q;
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	logic        wb_req;
	logic [31:0] rd_d;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (wb_adr_i)
			gas_pkg::REG_CTRL: begin
				rd_d[NDET-1:0] = det_en_q;
			end
			gas_pkg::REG_STATUS: begin
				rd_d[NDET-1:0]        = a1;
				rd_d[NDET+3:4]        = a2;
				rd_d[NDET+7:8]        = q1;
				rd_d[NDET+11:12]      = q2;
				rd_d[16]              = warm_done_q;
				rd_d[17]              = omem1_q;
				rd_d[18]              = omem2_q;
				rd_d[19]              = test;
			end
			default: begin
				rd_d = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req && !wb_we_i ? rd_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			det_en_q <= gas_pkg::CTRL_RESET[NDET-1:0];
		end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == gas_pkg::REG_CTRL) begin
			det_en_q <= wb_dat_i[NDET-1:0];
		end
	end

endmodule : gas_alarm_supervisor
`default_nettype wire

// file: bench/gas_det_model.sv
// model: two-threshold detectors whose concentration falls in steps
`timescale 1ns/1ps
`default_nettype none
module gas_det_model #(
	parameter int unsigned STEP = 20
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// requested level per detector, two bits each
	input  wire logic [7:0] gas_i,
	// threshold alarm lines
	output logic      [3:0] a1_o,
	output logic      [3:0] a2_o
);
	logic [1:0]  lvl_q [4];
	int unsigned cnt_q [4];

	// rise at once, fall one level per STEP+1 cycles
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_i || gas_i[2*i+:2] >= lvl_q[i]) begin
				lvl_q[i] <= rst_i ? 2'h0 : gas_i[2*i+:2];
				cnt_q[i] <= 0;
			end else if (cnt_q[i] < STEP) begin
				cnt_q[i] <= cnt_q[i] + 1;
			end else begin
				lvl_q[i] <= lvl_q[i] - 2'h1;
				cnt_q[i] <= 0;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			a1_o[i] = lvl_q[i] != 2'h0;
			a2_o[i] = lvl_q[i][1];
		end
	end
endmodule : gas_det_model
`default_nettype wire

// file: bench/gas_sup_checker.sv
// checker: concurrent properties on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module gas_sup_checker #(
	parameter int unsigned DELAY_CYC  = 100,
	parameter int unsigned WARMUP_CYC = 200
) (
	// clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// detector and switch inputs
	input wire logic [3:0]  first_threshold_alarm_i,
	input wire logic [3:0]  calibration_expired_i,
	input wire logic [3:0]  sensor_failed_i,
	input wire logic [3:0]  supply_overload_i,
	input wire logic        cascade_first_i,
	input wire logic        siren_mute_switch_i,
	input wire logic        latch_disable_switch_i,
	input wire logic        output_block_switch_i,
	input wire logic        test_button_i,
	// watched outputs
	input wire logic [3:0]  first_threshold_light_o,
	input wire logic        first_threshold_output_o,
	input wire logic        second_threshold_output_o,
	input wire logic        module_power_light_o,
	input wire logic        siren_o
);
	int unsigned wcnt_q;
	int unsigned qcnt_q;
	logic        wdone;

	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wcnt_q <= 0;
		else if (wcnt_q < WARMUP_CYC + 8)
			wcnt_q <= wcnt_q + 1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || first_threshold_alarm_i == 4'h0)
			qcnt_q <= 0;
		else if (qcnt_q < DELAY_CYC + 8)
			qcnt_q <= qcnt_q + 1;
	end

	assign wdone = wcnt_q > WARMUP_CYC + 4;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence mute_held;  siren_mute_switch_i [*8]; endsequence
	sequence block_held; output_block_switch_i [*8]; endsequence
	sequence latch_held; latch_disable_switch_i [*8]; endsequence

	// ----------------------------------------
	// properties
	// ----------------------------------------
	ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside acknowledge");
	mute_silent_a: assert property (mute_held |=> !siren_o)
		else $error("siren sounding while muted");
	block_outputs_a: assert property (block_held |=> !first_threshold_output_o && !second_threshold_output_o)
		else $error("control output active while blocked");
	qualify_delay_a: assert property ($rose(first_threshold_output_o) && !test_button_i && !cascade_first_i
		|-> qcnt_q >= DELAY_CYC + 1) else $error("control output before continuous delay");
	warm_dark_a: assert property (wcnt_q < WARMUP_CYC && (supply_overload_i | sensor_failed_i) == 4'h0
		|-> first_threshold_light_o == 4'h0) else $error("input light during warm-up");
	power_steady_a: assert property (wdone |-> module_power_light_o)
		else $error("module power light not steady after warm-up");
	light_follows_a: assert property (wdone && first_threshold_alarm_i[0] |=> first_threshold_light_o[0])
		else $error("input light not lit for active alarm");
	nomem_dark_a: assert property (latch_held ##0 $fell(first_threshold_alarm_i[0])
		##0 !supply_overload_i[0] && !sensor_failed_i[0] |=> !first_threshold_light_o[0])
		else $error("light latched with memory disabled");
endmodule : gas_sup_checker
`default_nettype wire

bind gas_alarm_supervisor gas_sup_checker #(.DELAY_CYC(DELAY_CYC), .WARMUP_CYC(WARMUP_CYC)) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .first_threshold_alarm_i(first_threshold_alarm_i),
	.calibration_expired_i(calibration_expired_i), .sensor_failed_i(sensor_failed_i),
	.supply_overload_i(supply_overload_i), .cascade_first_i(cascade_first_i),
	.siren_mute_switch_i(siren_mute_switch_i), .latch_disable_switch_i(latch_disable_switch_i),
	.output_block_switch_i(output_block_switch_i), .test_button_i(test_button_i),
	.first_threshold_light_o(first_threshold_light_o), .first_threshold_output_o(first_threshold_output_o),
	.second_threshold_output_o(second_threshold_output_o), .module_power_light_o(module_power_light_o),
	.siren_o(siren_o)
);

// file: bench/gas_alarm_supervisor_bench.sv
// testbench: scenarios for the gas alarm supervisor
`timescale 1ns/1ps
`default_nettype none
module gas_alarm_supervisor_bench;
	localparam logic [17:0] SIR = 18'h20000, MPW = 18'h10000, FTO = 18'h00800;
	localparam logic [17:0] STO = 18'h00400, FOL = 18'h00200, SOL = 18'h00100;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0]  adr = 8'h00, gas = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [3:0]  cal = 4'h0, sen = 4'h0, ovl = 4'h0, fus = 4'h0, sel = 4'hF, a1, a2, fl, sl, dp;
	logic        cf = 1'b0, cs = 1'b0, mute = 1'b0, nom = 1'b0, blk = 1'b0, clr = 1'b0, tst = 1'b0;
	logic        fto, sto, fol, sol, mpw, sir;
	logic [17:0] obs, seen_or, seen_and;
	int          err_count = 0, compares = 0;

	assign obs = {sir, mpw, dp, fto, sto, fol, sol, fl, sl};
	always #20 clk = ~clk;

	gas_det_model i_det (.clk_i(clk), .rst_i(rst), .gas_i(gas), .a1_o(a1), .a2_o(a2));
	gas_alarm_supervisor #(.DELAY_CYC(100), .WARMUP_CYC(200), .FLASH_CYC(4), .DEB_CYC(3),
		.HIDE_CYC(50)) i_dut (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.first_threshold_alarm_i(a1), .second_threshold_alarm_i(a2), .calibration_expired_i(cal),
		.sensor_failed_i(sen), .supply_overload_i(ovl), .fuse_tripped_i(fus), .cascade_first_i(cf),
		.cascade_second_i(cs), .siren_mute_switch_i(mute), .latch_disable_switch_i(nom),
		.output_block_switch_i(blk), .latch_clear_button_i(clr), .test_button_i(tst),
		.first_threshold_light_o(fl), .second_threshold_light_o(sl), .first_output_light_o(fol),
		.second_output_light_o(sol), .first_threshold_output_o(fto), .second_threshold_output_o(sto),
		.detector_power_light_o(dp), .module_power_light_o(mpw), .siren_o(sir));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// mode 0 dark, 1 steady, 2 flashing, 3 seen lit
	task look(input string n, input int c, input logic [17:0] m, input int k);
		seen_or = 18'h0;
		seen_and = 18'h3FFFF;
		repeat (c) begin
			@(negedge clk);
			seen_or = seen_or | obs;
			seen_and = seen_and & obs;
		end
		@(posedge clk);
		if (k == 1)
			chk(n, {14'h0, seen_and & m}, {14'h0, m});
		else
			chk(n, {14'h0, seen_or & m}, k == 0 ? 32'h0 : {14'h0, m});
		if (k == 2)
			chk(n, {14'h0, seen_and & m}, 32'h0);
	endtask : look

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) begin
			err_count++;
			wrap_up();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : bus

	task press;
		clr <= 1'b1;
		tick(10);
		clr <= 1'b0;
		tick(10);
	endtask : press

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_warm;
		gas <= 8'h01;
		look("warm light", 20, 18'h00010 | SIR, 0);
		look("warm power", 12, MPW, 2);
		gas <= 8'h00;
		cf <= 1'b1;
		cs <= 1'b1;
		look("cascade siren", 12, SIR, 2);
		look("cascade outputs", 4, FTO | STO, 1);
		cf <= 1'b0;
		cs <= 1'b0;
		$display("test warm done");
	endtask : t_warm

	task t_bus;
		bus(1'b0, gas_pkg::REG_CTRL, 32'h0);
		chk("ctrl reset", r, {28'h0, gas_pkg::CTRL_RESET});
		bus(1'b1, gas_pkg::REG_CTRL, 32'h3);
		bus(1'b0, gas_pkg::REG_CTRL, 32'h0);
		chk("ctrl write", r, 32'h3);
		bus(1'b1, gas_pkg::REG_CTRL, 32'hF);
		sel <= 4'hE;
		bus(1'b1, gas_pkg::REG_CTRL, 32'h0);
		sel <= 4'hF;
		bus(1'b0, gas_pkg::REG_CTRL, 32'h0);
		chk("sel gated", r, 32'hF);
		bus(1'b0, 8'h08, 32'h0);
		chk("unmapped", r, 32'h0);
		bus(1'b0, gas_pkg::REG_STATUS, 32'h0);
		chk("status idle", r & 32'h0001FFFF, 32'h00010000);
		$display("test bus done");
	endtask : t_bus

	task t_alarm;
		gas <= 8'h01;
		tick(3);
		look("a1 light", 8, 18'h00010, 1);
		look("a1 siren", 12, SIR, 2);
		tick(30);
		gas <= 8'h00;
		tick(24);
		gas <= 8'h01;
		tick(90);
		look("restart", 2, FTO | FOL, 0);
		tick(20);
		look("qualified", 4, FTO | FOL, 1);
		gas <= 8'h06;
		tick(5);
		gas <= 8'h04;
		tick(24);
		look("a2 first", 12, 18'h00001, 2);
		look("a1 still", 1, 18'h00010, 1);
		tick(10);
		look("a1 memory", 12, 18'h00010, 2);
		press;
		look("clear flash", 8, 18'h00011, 0);
		look("steady kept", 4, 18'h00020, 1);
		gas <= 8'h00;
		tick(30);
		press;
		$display("test alarm done");
	endtask : t_alarm

	task t_switches;
		mute <= 1'b1;
		tick(10);
		gas <= 8'h01;
		tick(3);
		look("muted siren", 16, SIR, 0);
		look("muted light", 4, 18'h00010, 1);
		mute <= 1'b0;
		gas <= 8'h00;
		tick(30);
		press;
		nom <= 1'b1;
		tick(10);
		gas <= 8'h01;
		tick(5);
		gas <= 8'h00;
		tick(25);
		look("no memory", 8, 18'h00010, 0);
		nom <= 1'b0;
		$display("test switches done");
	endtask : t_switches

	task t_test;
		tst <= 1'b1;
		tick(10);
		look("test held", 8, FTO | STO | FOL | SOL, 1);
		look("test inputs", 4, 18'h000FF, 0);
		tst <= 1'b0;
		tick(10);
		look("test release", 12, FTO | STO, 0);
		look("test memory", 12, FOL | SOL, 2);
		press;
		look("test cleared", 8, FOL | SOL, 0);
		blk <= 1'b1;
		tick(10);
		tst <= 1'b1;
		tick(10);
		look("blocked", 8, FTO | STO, 0);
		look("blocked lights", 4, FOL | SOL, 1);
		tst <= 1'b0;
		tick(10);
		blk <= 1'b0;
		tick(10);
		press;
		$display("test button done");
	endtask : t_test

	task t_faults;
		cal <= 4'h4;
		tick(40);
		look("calib flash", 20, 18'h00004, 2);
		look("calib first", 4, 18'h00040, 0);
		press;
		look("calib hidden", 20, 18'h00004, 0);
		tick(30);
		look("calib back", 20, 18'h00004, 2);
		cal <= 4'h0;
		sen <= 4'h8;
		tick(3);
		look("sensor flash", 20, 18'h00088, 2);
		sen <= 4'h0;
		ovl <= 4'h1;
		tick(3);
		look("overload", 8, 18'h00011, 1);
		ovl <= 4'h0;
		fus <= 4'h2;
		tick(3);
		look("fuse power", 20, 18'h02000, 2);
		look("fuse alarm", 20, 18'h00002, 3);
		fus <= 4'h0;
		$display("test faults done");
	endtask : t_faults

	initial begin
		tick(4);
		rst <= 1'b0;
		tick(1);
		t_warm();
		tick(230);
		press();
		t_bus();
		t_alarm();
		t_switches();
		t_test();
		t_faults();
		wrap_up();
	end
endmodule : gas_alarm_supervisor_bench
`default_nettype wire
